/* File: rtl/alarm_resp_params.svh */
// Constants for the security alarm response unit
`ifndef ALARM_RESP_PARAMS_SVH
`define ALARM_RESP_PARAMS_SVH
// ==========================================================
// Register offsets (byte addresses)
`define OFF_RESET_CAUSE 12'h000
`define OFF_EXC_REASON 12'h004
`define OFF_IRQ_MASK 12'h008
`define OFF_LIGHT_CFG 12'h00c
`define OFF_NVM_CFG 12'h010
`define OFF_HV_STATUS 12'h014
`define OFF_SENSOR_EN 12'h018
`define OFF_CTRL 12'h01c
// ==========================================================
// Reset cause field positions
`define RC_VOLT 0
`define RC_FREQ 1
`define RC_TEMP 2
`define RC_LIGHT 3
`define RC_ROM_PAR 4
`define RC_POWER_ON 5
`define RC_W 6
// ==========================================================
// Exception reason field positions
`define EX_MEM_LIGHT 0
`define EX_PC 1
`define EX_SP 2
`define EX_STATUS_WORD 3
`define EX_CIPHER 4
`define EX_ARITH 5
`define EX_STK_USER 6
`define EX_STK_SYS 7
`define EX_STK_SUPER 8
`define EX_ECC 9
`define EX_W 10
// ==========================================================
// Reset values and timing
`define RST_LIGHT_CFG 2'h1
`define RST_NVM_CFG 1'h0
`define RST_IRQ_MASK 10'h3ff
`define RESET_HOLD_NS 100
`define CLK_PERIOD_NS 25
`define RESET_HOLD_CYC ((`RESET_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SENSOR_ALL_ON 4'hf
`endif

/* File: rtl/alarm_resp_pkg.sv */
// Types for the security alarm response unit
package alarm_resp_pkg;
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_RESET = 3'b010,
    ST_TEST = 3'b100
  } phase_type;
  typedef enum logic [1:0] {
    LD_OFF = 2'h0,
    LD_FUNC_A = 2'h1,
    LD_FUNC_B = 2'h2
  } light_sel_type;
  typedef struct packed {
    phase_type phase;
    logic [2:0] hold_cnt;
    logic [5:0] reset_cause;
    logic [9:0] exc_reason;
    logic [9:0] irq_mask;
    logic [1:0] light_sel;
    logic nvm_inv_ecc;
    logic hv_ok;
    logic hv_valid;
    logic [31:0] prdata;
    logic [7:0] nvm_data;
    logic nvm_valid;
    logic exc_pulse;
  } state_type;
endpackage

/* File: rtl/security_alarm_response_unit.sv */
// Security alarm response unit: sensor alarms to chip reset or CPU exception
// Functional notes
// RL1 - Voltage, frequency, temperature or light alarm forces a full chip reset.
// RL2 - Memory light detector or single-fault detector raises an exception instead.
// RL3 - Exception interrupts program flow; reset aborts the running program.
// RL4 - Any reset returns every register to its reset value.
// RL5 - Software can read the cause of the most recent reset.
// RL6 - Software can read which source caused an exception.
// RL7 - Outside factory test mode all sensors are enabled automatically.
// RL8 - Software writes cannot disable the environmental sensors.
// RL9 - Sensor to response mapping is hardwired, no register changes it.
// RL10 - Memory light detection offers two functions, selectable or both off.
// RL11 - PC, stack pointer, status word, cipher, arithmetic faults feed exceptions.
// RL12 - Separate stack limit checks per mode; reaching a limit raises exception.
// RL13 - High-voltage check only sets a status value; no exception or reset.
// RL14 - With inverse error correction on, a detected error raises an exception.
// RL15 - Nonvolatile read path corrects a single-bit error per byte automatically.
// RL16 - Read-only memory parity error forces a chip reset.
// RL17 - Simultaneous exception sources are all recorded in the reason indicator.
`timescale 1ns/1ps
`default_nettype none
`include "alarm_resp_params.svh"
module security_alarm_response_unit import alarm_resp_pkg::*; (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Mode strap
  input wire logic i_test_mode,
  // Environmental sensors
  input wire logic i_alarm_volt,
  input wire logic i_alarm_freq,
  input wire logic i_alarm_temp,
  input wire logic i_alarm_light,
  input wire logic i_rom_parity_err,
  // Memory light detector, two functions
  input wire logic i_mem_light_a,
  input wire logic i_mem_light_b,
  // Single-fault detectors
  input wire logic i_fault_pc,
  input wire logic i_fault_sp,
  input wire logic i_fault_status_word,
  input wire logic i_fault_cipher,
  input wire logic i_fault_arith,
  // Stack limit checks
  input wire logic [1:0] i_cpu_mode,
  input wire logic [15:0] i_sp_user,
  input wire logic [15:0] i_sp_sys,
  input wire logic [15:0] i_sp_super,
  input wire logic [15:0] i_sp_lim_user,
  input wire logic [15:0] i_sp_lim_sys,
  input wire logic [15:0] i_sp_lim_super,
  // Nonvolatile memory
  input wire logic i_hv_check_done,
  input wire logic i_hv_check_ok,
  input wire logic i_nvm_rd_valid,
  input wire logic [7:0] i_nvm_rd_data,
  input wire logic [3:0] i_nvm_rd_check,
  input wire logic i_nvm_inv_err,
  output logic [7:0] o_nvm_data,
  output logic o_nvm_valid,
  // CPU side
  output logic o_chip_reset,
  output logic o_cpu_exception,
  output logic o_irq,
  output logic [3:0] o_sensor_en
);
  // ========================================================
  // Hamming SEC decode for one byte
  function automatic logic [7:0] sec_fix(input logic [7:0] d, input logic [3:0] c);
    logic [3:0] s;
    logic [7:0] f;
    s = 4'h0;
    f = d;
    s[0] = c[0] ^ d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6];
    s[1] = c[1] ^ d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
    s[2] = c[2] ^ d[1] ^ d[2] ^ d[3] ^ d[7];
    s[3] = c[3] ^ d[4] ^ d[5] ^ d[6] ^ d[7];
    case (s)
      4'h3: f[0] = ~d[0];
      4'h5: f[1] = ~d[1];
      4'h6: f[2] = ~d[2];
      4'h7: f[3] = ~d[3];
      4'h9: f[4] = ~d[4];
      4'ha: f[5] = ~d[5];
      4'hb: f[6] = ~d[6];
      4'hc: f[7] = ~d[7];
      default: f = d;
    endcase
    return f;
  endfunction

  state_type st_r;
  state_type st_nxt;
  logic [3:0] sensor_en;
  logic env_alarm;
  logic [`RC_W-1:0] cause_now;
  logic [`EX_W-1:0] exc_now;
  logic mem_light;
  logic wr_acc;
  logic rd_acc;
  logic addr_ok;

  // ========================================================
  // Sensor enables: hardwired, software has no write path
  assign sensor_en = i_test_mode ? 4'h0 : `SENSOR_ALL_ON; // RL7 RL8

  // ========================================================
  // Fixed alarm routing
  assign cause_now[`RC_VOLT] = i_alarm_volt & sensor_en[0]; // RL1 RL9
  assign cause_now[`RC_FREQ] = i_alarm_freq & sensor_en[1]; // RL1
  assign cause_now[`RC_TEMP] = i_alarm_temp & sensor_en[2]; // RL1
  assign cause_now[`RC_LIGHT] = i_alarm_light & sensor_en[3]; // RL1
  assign cause_now[`RC_ROM_PAR] = i_rom_parity_err; // RL16
  assign cause_now[`RC_POWER_ON] = 1'b0;
  assign env_alarm = |cause_now;

  always_comb begin
    case (st_r.light_sel)
      LD_FUNC_A: mem_light = i_mem_light_a; // RL10
      LD_FUNC_B: mem_light = i_mem_light_b; // RL10
      default: mem_light = 1'b0;
    endcase
  end

  assign exc_now[`EX_MEM_LIGHT] = mem_light; // RL2
  assign exc_now[`EX_PC] = i_fault_pc; // RL11
  assign exc_now[`EX_SP] = i_fault_sp; // RL11
  assign exc_now[`EX_STATUS_WORD] = i_fault_status_word; // RL11
  assign exc_now[`EX_CIPHER] = i_fault_cipher; // RL11
  assign exc_now[`EX_ARITH] = i_fault_arith; // RL11
  assign exc_now[`EX_STK_USER] = (i_cpu_mode == 2'h0) && (i_sp_user >= i_sp_lim_user); // RL12
  assign exc_now[`EX_STK_SYS] = (i_cpu_mode == 2'h1) && (i_sp_sys >= i_sp_lim_sys); // RL12
  assign exc_now[`EX_STK_SUPER] = (i_cpu_mode[1]) && (i_sp_super >= i_sp_lim_super); // RL12
  assign exc_now[`EX_ECC] = st_r.nvm_inv_ecc & i_nvm_rd_valid & i_nvm_inv_err; // RL14

  // ========================================================
  // APB decode; zero wait states
  assign addr_ok = (i_paddr[1:0] == 2'h0) && (i_paddr <= `OFF_CTRL);
  assign wr_acc = i_psel & i_penable & i_pwrite;
  assign rd_acc = i_psel & ~i_penable & ~i_pwrite;

  // ========================================================
  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.exc_pulse = 1'b0;
    st_nxt.nvm_valid = i_nvm_rd_valid;
    if (i_nvm_rd_valid) begin
      st_nxt.nvm_data = sec_fix(i_nvm_rd_data, i_nvm_rd_check); // RL15
    end
    if (i_hv_check_done) begin
      st_nxt.hv_ok = i_hv_check_ok; // RL13
      st_nxt.hv_valid = 1'b1;
    end
    case (st_r.phase)
      ST_RUN, ST_TEST: begin
        st_nxt.phase = i_test_mode ? ST_TEST : ST_RUN;
        if (wr_acc && addr_ok) begin
          case (i_paddr)
            `OFF_EXC_REASON: st_nxt.exc_reason = st_r.exc_reason & ~i_pwdata[`EX_W-1:0];
            `OFF_IRQ_MASK: st_nxt.irq_mask = i_pwdata[`EX_W-1:0];
            `OFF_LIGHT_CFG: st_nxt.light_sel = (i_pwdata[1:0] == 2'h3) ? st_r.light_sel : i_pwdata[1:0]; // RL10
            `OFF_NVM_CFG: st_nxt.nvm_inv_ecc = i_pwdata[0];
            `OFF_HV_STATUS: st_nxt.hv_valid = (st_r.hv_valid & ~i_pwdata[1]) | i_hv_check_done; // RL13
            default: st_nxt.reset_cause = st_r.reset_cause;
          endcase
        end
        // Set beats clear, every source kept
        st_nxt.exc_reason = st_nxt.exc_reason | exc_now; // RL6 RL17
        st_nxt.exc_pulse = |exc_now; // RL3
        if (env_alarm) begin
          // Whole state to defaults except the recorded cause
          st_nxt = '0; // RL4
          st_nxt.phase = ST_RESET; // RL1 RL3
          st_nxt.reset_cause = cause_now; // RL5
          st_nxt.hold_cnt = 3'(`RESET_HOLD_CYC);
          st_nxt.light_sel = `RST_LIGHT_CFG;
          st_nxt.irq_mask = `RST_IRQ_MASK;
        end
      end
      ST_RESET: begin
        // Hold reset long enough for the core, re-arm on a new alarm, release on expiry
        st_nxt.reset_cause = st_r.reset_cause | cause_now;
        if (env_alarm) begin
          st_nxt.hold_cnt = 3'(`RESET_HOLD_CYC);
        end else if (st_r.hold_cnt != 3'h0) begin
          st_nxt.hold_cnt = st_r.hold_cnt - 3'h1;
        end else begin
          st_nxt.phase = ST_RUN;
        end
      end
      default: st_nxt.phase = ST_RESET;
    endcase
    if (rd_acc) begin
      case (i_paddr)
        `OFF_RESET_CAUSE: st_nxt.prdata = {26'h0, st_r.reset_cause};
        `OFF_EXC_REASON: st_nxt.prdata = {22'h0, st_r.exc_reason};
        `OFF_IRQ_MASK: st_nxt.prdata = {22'h0, st_r.irq_mask};
        `OFF_LIGHT_CFG: st_nxt.prdata = {30'h0, st_r.light_sel};
        `OFF_NVM_CFG: st_nxt.prdata = {31'h0, st_r.nvm_inv_ecc};
        `OFF_HV_STATUS: st_nxt.prdata = {30'h0, st_r.hv_valid, st_r.hv_ok};
        `OFF_SENSOR_EN: st_nxt.prdata = {28'h0, sensor_en};
        `OFF_CTRL: st_nxt.prdata = {30'h0, st_r.phase == ST_TEST, st_r.phase == ST_RESET};
        default: st_nxt.prdata = 32'h0;
      endcase
    end
  end

  // ========================================================
  // State register
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      st_r <= '0; // RL4
      st_r.phase <= ST_RESET;
      st_r.hold_cnt <= 3'(`RESET_HOLD_CYC);
      st_r.reset_cause <= 6'h20; // RL5
      st_r.irq_mask <= `RST_IRQ_MASK;
      st_r.light_sel <= `RST_LIGHT_CFG;
      st_r.nvm_inv_ecc <= `RST_NVM_CFG;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ========================================================
  // Outputs
  assign o_prdata = st_r.prdata;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~addr_ok;
  assign o_chip_reset = (st_r.phase == ST_RESET); // RL1 RL16
  assign o_cpu_exception = st_r.exc_pulse; // RL2
  assign o_irq = |(st_r.exc_reason & st_r.irq_mask);
  assign o_sensor_en = sensor_en;
  assign o_nvm_data = st_r.nvm_data;
  assign o_nvm_valid = st_r.nvm_valid;

  // ========================================================
  // Checks: reset path

  a_env_reset: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RL1
    (st_r.phase != ST_RESET && (i_alarm_volt | i_alarm_temp) && !i_test_mode) |=> o_chip_reset)
    else $error("env alarm did not reset");

  a_freq_reset: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RL1
    (st_r.phase != ST_RESET && i_alarm_freq && !i_test_mode) |=> o_chip_reset)
    else $error("frequency alarm did not reset");

  a_hold_length: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RL1
    $rose(o_chip_reset) |-> o_chip_reset [*5])
    else $error("reset released early");

  a_rom_reset: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RL16
    (st_r.phase != ST_RESET && i_rom_parity_err) |=> ##[0:1] o_chip_reset)
    else $error("parity did not reset");

  a_rom_cause: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RL16
    (st_r.phase != ST_RESET && i_rom_parity_err) |=> st_r.reset_cause[`RC_ROM_PAR])
    else $error("parity cause missing");

  a_reset_clears: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RL4
    $rose(o_chip_reset) |-> (st_r.exc_reason == 10'h0 && st_r.nvm_inv_ecc == 1'b0))
    else $error("reset left state");

  a_reset_defaults: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RL4
    $rose(o_chip_reset) |->
      (st_r.irq_mask == `RST_IRQ_MASK && st_r.light_sel == `RST_LIGHT_CFG && !st_r.hv_valid))
    else $error("reset defaults wrong");

  a_cause_kept: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RL5
    (st_r.phase == ST_RUN && i_alarm_temp && !i_test_mode) |=> st_r.reset_cause[`RC_TEMP])
    else $error("reset cause missing");

  a_cause_exact: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RL5
    $rose(o_chip_reset) |-> (st_r.reset_cause == $past(cause_now)))
    else $error("reset cause not exact");

  a_reset_no_exc: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RL3
    o_chip_reset |-> !o_cpu_exception)
    else $error("exception during reset");

  // ========================================================
  // Checks: exception path

  a_exc_no_reset: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RL2
    (st_r.phase == ST_RUN && i_fault_pc && !env_alarm) |=> (o_cpu_exception && !o_chip_reset))
    else $error("fault did not raise exception");

  a_exc_pulse_cause: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RL3
    o_cpu_exception |-> $past(|exc_now))
    else $error("exception without source");

  a_reason_sticky: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RL6
    (st_r.exc_reason[`EX_PC] && !env_alarm && st_r.phase == ST_RUN && !wr_acc) |=> st_r.exc_reason[`EX_PC])
    else $error("reason lost");

  a_reason_set: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RL6
    (st_r.phase == ST_RUN && !env_alarm && exc_now != 10'h0)
      |=> ((st_r.exc_reason & $past(exc_now)) == $past(exc_now)))
    else $error("reason not recorded");

  a_all_sources: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RL17
    (st_r.phase == ST_RUN && !env_alarm && i_fault_cipher && i_fault_arith)
      |=> (st_r.exc_reason[`EX_CIPHER] && st_r.exc_reason[`EX_ARITH]))
    else $error("source dropped");

  a_fault_status: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RL11
    (st_r.phase == ST_RUN && i_fault_status_word && !env_alarm)
      |=> (st_r.exc_reason[`EX_STATUS_WORD] && !o_chip_reset))
    else $error("status word fault lost");

  a_stack_user: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RL12
    (st_r.phase == ST_RUN && i_cpu_mode == 2'h0 && i_sp_user >= i_sp_lim_user && !env_alarm)
      |=> st_r.exc_reason[`EX_STK_USER])
    else $error("user stack limit missed");

  a_stack_split: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RL12
    (i_cpu_mode == 2'h0) |-> (!exc_now[`EX_STK_SYS] && !exc_now[`EX_STK_SUPER]))
    else $error("idle stack checked");

  a_ecc_exc: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RL14
    (st_r.phase == ST_RUN && st_r.nvm_inv_ecc && i_nvm_rd_valid && i_nvm_inv_err && !env_alarm)
      |=> (o_cpu_exception && st_r.exc_reason[`EX_ECC]))
    else $error("ecc error not raised");

  a_ecc_off: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RL14
    !st_r.nvm_inv_ecc |-> !exc_now[`EX_ECC])
    else $error("ecc raised while off");

  a_light_func: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RL10
    (st_r.phase == ST_RUN && st_r.light_sel == 2'h2 && i_mem_light_b && !env_alarm)
      |=> st_r.exc_reason[`EX_MEM_LIGHT])
    else $error("light function missed");

  a_light_off: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RL10
    (st_r.light_sel == 2'h0) |-> !exc_now[`EX_MEM_LIGHT])
    else $error("light detect while off");

  // ========================================================
  // Checks: sensors, configuration and memory

  a_sensors_on: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RL7
    !i_test_mode |-> o_sensor_en == 4'hf)
    else $error("sensor disabled");

  a_sensors_test: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RL7
    i_test_mode |-> o_sensor_en == 4'h0)
    else $error("sensor on in test mode");

  a_sensor_fixed: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RL8
    $stable(i_test_mode) |-> $stable(o_sensor_en))
    else $error("sensor enable moved");

  a_light_map: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RL9
    (st_r.phase != ST_RESET && i_alarm_light && !i_test_mode) |=> (o_chip_reset && !o_cpu_exception))
    else $error("light sensor misrouted");

  a_light_legal: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RL10
    st_r.light_sel != 2'h3)
    else $error("light select illegal");

  a_hv_no_event: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RL13
    (i_hv_check_done && !i_hv_check_ok && exc_now == 10'h0 && !env_alarm && st_r.phase == ST_RUN)
      |=> (!o_cpu_exception && !o_chip_reset))
    else $error("hv check caused event");

  a_hv_status: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RL13
    (i_hv_check_done && !env_alarm)
      |=> (st_r.hv_valid && st_r.hv_ok == $past(i_hv_check_ok)))
    else $error("hv status not kept");

  a_nvm_fix: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RL15
    (i_nvm_rd_valid && i_nvm_rd_check == 4'h0 && $onehot(i_nvm_rd_data) && !env_alarm)
      |=> (o_nvm_valid && o_nvm_data == 8'h0))
    else $error("single bit not corrected");
endmodule
`default_nettype wire

/* File: sim/alarm_source_model.sv */
// Alarm source model: sensors, fault detectors and ECC flag driving the unit
`timescale 1ns/1ps
`default_nettype none
module alarm_source_model (
  // Clock and commands
  input wire logic i_clk_sys,
  input wire logic [4:0] i_env_cmd,
  input wire logic [7:0] i_flt_cmd,
  // Alarm pins
  output logic [4:0] o_env,
  output logic [7:0] o_flt
);
  // =====
  // Alarm launch
  // Registered, so an alarm never lands in the same step as the command
  always_ff @(posedge i_clk_sys) begin
    o_env <= i_env_cmd;
    o_flt <= i_flt_cmd;
  end
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
// Self-checking bench for the security alarm response unit
`timescale 1ns/1ps
`default_nettype none
`include "alarm_resp_params.svh"
module tb_top;
  // =====
  // Signals
  logic i_clk_sys = 1'b0, i_rst = 1'b1, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0, i_test_mode = 1'b0;
  logic i_hv_check_done = 1'b0, i_hv_check_ok = 1'b0, i_nvm_rd_valid = 1'b0, err;
  logic o_pready, o_pslverr, o_nvm_valid, o_chip_reset, o_cpu_exception, o_irq;
  logic [11:0] i_paddr = 12'h0;
  logic [31:0] i_pwdata = 32'h0, o_prdata, rd, v;
  logic [7:0] i_nvm_rd_data = 8'h0, o_nvm_data, flt_cmd = 8'h0, flt;
  logic [4:0] env_cmd = 5'h0, env;
  logic [3:0] i_nvm_rd_check = 4'h0, o_sensor_en;
  logic [1:0] i_cpu_mode = 2'h0;
  logic [15:0] sp [3] = '{default: 16'h0};
  logic [15:0] lim [3] = '{default: 16'hffff};
  logic [9:0] exp_reason = 10'h0, mask_m = 10'h3ff;
  logic [31:0] rv [8] = '{32'h20, 32'h0, 32'h3ff, 32'h1, 32'h0, 32'h0, 32'hf, 32'h0};
  int num_errors = 0, total_checks = 0, seed = 59866, i, k;

  security_alarm_response_unit dut (
    .i_clk_sys, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
    .i_test_mode, .i_alarm_volt(env[0]), .i_alarm_freq(env[1]), .i_alarm_temp(env[2]), .i_alarm_light(env[3]),
    .i_rom_parity_err(env[4]), .i_mem_light_a(flt[0]), .i_mem_light_b(flt[1]), .i_fault_pc(flt[2]),
    .i_fault_sp(flt[3]), .i_fault_status_word(flt[4]), .i_fault_cipher(flt[5]), .i_fault_arith(flt[6]),
    .i_cpu_mode, .i_sp_user(sp[0]), .i_sp_sys(sp[1]), .i_sp_super(sp[2]), .i_sp_lim_user(lim[0]),
    .i_sp_lim_sys(lim[1]), .i_sp_lim_super(lim[2]), .i_hv_check_done, .i_hv_check_ok, .i_nvm_rd_valid,
    .i_nvm_rd_data, .i_nvm_rd_check, .i_nvm_inv_err(flt[7]), .o_nvm_data, .o_nvm_valid, .o_chip_reset,
    .o_cpu_exception, .o_irq, .o_sensor_en
  );
  alarm_source_model partner (.i_clk_sys, .i_env_cmd(env_cmd), .i_flt_cmd(flt_cmd), .o_env(env), .o_flt(flt));

  initial begin
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end

  // =====
  // Checking and bus tasks
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp_pin(input string nm, input logic e, input logic g);
    cmp(nm, {31'h0, e}, {31'h0, g});
  endtask

  // Entered just after an edge; leaves one edge after release
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk_sys);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      final_report();
    end
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clk_sys);
  endtask

  task automatic wait_reset(input logic lv);
    int n;
    n = 0;
    while (o_chip_reset !== lv && n < 40) begin
      @(posedge i_clk_sys);
      n++;
    end
    if (n >= 40) begin
      num_errors++;
      final_report();
    end
  endtask

  task automatic fire(input logic [7:0] f);
    flt_cmd <= f;
    @(posedge i_clk_sys);
    flt_cmd <= 8'h0;
  endtask

  // Model: reason bits accumulate until a write of ones clears them
  task automatic exc_check(input logic [9:0] b);
    logic seen;
    seen = 1'b0;
    repeat (5) begin
      @(posedge i_clk_sys);
      seen = seen | (o_cpu_exception === 1'b1);
      cmp_pin("chip_reset", 1'b0, o_chip_reset);
    end
    cmp_pin("exception", |b, seen);
    exp_reason = exp_reason | b;
    apb(1'b0, `OFF_EXC_REASON, 32'h0);
    cmp("exc_reason", {22'h0, exp_reason}, rd);
    cmp_pin("irq", |(exp_reason & mask_m), o_irq);
    apb(1'b1, `OFF_EXC_REASON, 32'h3ff);
    exp_reason = 10'h0;
    cmp_pin("irq cleared", 1'b0, o_irq);
  endtask

  // =====
  // Main sequence
  initial begin
    repeat (2) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    cmp_pin("chip_reset", 1'b1, o_chip_reset);
    wait_reset(1'b0);
    apb(1'b1, `OFF_RESET_CAUSE, 32'h0);
    apb(1'b1, `OFF_SENSOR_EN, 32'h0);
    for (i = 0; i < 8; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0);
      cmp("reset value", rv[i], rd);
    end
    apb(1'b0, 12'h020, 32'h0);
    cmp_pin("pslverr", 1'b1, err);
    cmp("unmapped read", 32'h0, rd);
    cmp("sensor_en", 32'hf, {28'h0, o_sensor_en});
    i_test_mode <= 1'b1;
    env_cmd <= 5'h1;
    @(posedge i_clk_sys);
    cmp("test sensor_en", 32'h0, {28'h0, o_sensor_en});
    env_cmd <= 5'h0;
    apb(1'b0, `OFF_CTRL, 32'h0);
    cmp("ctrl test", 32'h2, rd);
    cmp_pin("test chip_reset", 1'b0, o_chip_reset);
    i_test_mode <= 1'b0;
    for (i = 2; i < 7; i++) begin
      fire(8'(1 << i));
      exc_check(10'(1 << (i - 1)));
    end
    for (i = 0; i < 4; i++) begin
      v = $random(seed) & 32'h7c;
      fire(v[7:0]);
      exc_check({4'h0, v[6:2], 1'b0});
    end
    for (i = 0; i < 3; i++) begin
      apb(1'b1, `OFF_LIGHT_CFG, 32'(i));
      fire(8'h01);
      exc_check({9'h0, i == 1});
      fire(8'h02);
      exc_check({9'h0, i == 2});
    end
    apb(1'b1, `OFF_LIGHT_CFG, 32'h3);
    apb(1'b0, `OFF_LIGHT_CFG, 32'h0);
    cmp("light_cfg", 32'h2, rd);
    for (i = 0; i < 2; i++) begin
      apb(1'b1, `OFF_NVM_CFG, 32'(i));
      fire(8'h80);
      // Read strobe lined up with the partner's one-cycle late error flag
      i_nvm_rd_valid <= 1'b1;
      @(posedge i_clk_sys);
      i_nvm_rd_valid <= 1'b0;
      exc_check(10'(i << 9));
    end
    for (i = 0; i < 3; i++) begin
      v = $random(seed);
      lim[i] <= v[15:0] | 16'h1;
      sp[i] <= v[15:0] | 16'h1;
      i_cpu_mode <= 2'(i);
      @(posedge i_clk_sys);
      sp[i] <= 16'h0;
      exc_check(10'(10'h40 << i));
    end
    apb(1'b1, `OFF_IRQ_MASK, 32'h1);
    mask_m = 10'h1;
    fire(8'h04);
    exc_check(10'h2);
    apb(1'b1, `OFF_IRQ_MASK, 32'h3ff);
    mask_m = 10'h3ff;
    i_hv_check_ok <= 1'b1;
    i_hv_check_done <= 1'b1;
    @(posedge i_clk_sys);
    i_hv_check_done <= 1'b0;
    exc_check(10'h0);
    apb(1'b0, `OFF_HV_STATUS, 32'h0);
    cmp("hv_status", 32'h3, rd);
    k = $random(seed) & 7;
    i_nvm_rd_data <= 8'(1 << k);
    i_nvm_rd_valid <= 1'b1;
    @(posedge i_clk_sys);
    i_nvm_rd_valid <= 1'b0;
    @(posedge i_clk_sys);
    cmp_pin("nvm_valid", 1'b1, o_nvm_valid);
    cmp("nvm_data", 32'h0, {24'h0, o_nvm_data});
    // Alarm resets last: they wipe all software state
    for (i = 0; i < 5; i++) begin
      apb(1'b1, `OFF_IRQ_MASK, 32'h0);
      env_cmd <= 5'(1 << i);
      @(posedge i_clk_sys);
      env_cmd <= 5'h0;
      wait_reset(1'b1);
      cmp_pin("chip_reset", 1'b1, o_chip_reset);
      cmp_pin("exception", 1'b0, o_cpu_exception);
      // Write inside the hold is dropped; the read still lands before the hold ends
      apb(1'b1, `OFF_IRQ_MASK, 32'h0);
      apb(1'b0, `OFF_CTRL, 32'h0);
      cmp("ctrl in reset", 32'h1, rd);
      wait_reset(1'b0);
      apb(1'b0, `OFF_RESET_CAUSE, 32'h0);
      cmp("reset_cause", 32'(1 << i), rd);
      apb(1'b0, `OFF_IRQ_MASK, 32'h0);
      cmp("irq_mask", 32'h3ff, rd);
    end
    final_report();
  end
endmodule
`default_nettype wire
